// [hwlt_timer.sv]
// Hardware limit timer with peripheral resets, Avalon-MM slave
// Functional notes
// - Count instruction clock through prescaler
// - Match period: pulse output, count returns 00h
// - Resets clear count, period FFh, scalers
// - Control0 write keeps count unchanged
// - Postscaler overflow sets match flag
// - Interrupt passes only when enabled
// - Postscale code N divides by N+1
// - On bit runs, clear stops
// - Prescale codes divide 1, 4, 16, 64
// - Source select, codes 110/111 give zero
// - Rising event enable clears count
// - Falling event enable clears count
// - Falling events edge or level sensitive
// - Rising events edge or level sensitive
// - External clears happen on timer clock
// - Count write beats pending external reset
// - Early external reset suppresses match
// - Unscaled match goes to output generator
// - Sleep holds count and stops timer
// - Control bits reset zero, unused read zero
`timescale 1ns/1ps
`default_nettype none
module hwlt_timer
	import hwlt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sleep_mode,
	input wire logic capture_compare_out,
	input wire logic comparator1_out,
	input wire logic comparator2_out,
	input wire logic gen_fault_pin,
	input wire logic gen_output0,
	input wire logic gen_output1,
	output logic limit_match,
	output logic limit_irq
);

	// ************************************************************
	// Decode helpers
	// ************************************************************
	function automatic logic [5:0] pre_mask(input logic [1:0] sel);
		logic [5:0] m;
		m = PRE_MASK1;
		case (sel)
			2'h1: m = PRE_MASK4;
			2'h2: m = PRE_MASK16;
			2'h3: m = PRE_MASK64;
			default: m = PRE_MASK1;
		endcase
		return m;
	endfunction

	function automatic logic src_pick(input logic [2:0] sel,
		input logic [SRC_CNT-1:0] v);
		logic b;
		b = 1'b0;
		if (sel < 3'h6) begin
			b = v[sel];
		end
		return b;
	endfunction

	hwlt_state_type s_r;
	hwlt_state_type s_nxt;

	logic [SRC_CNT-1:0] src_vec;
	logic req;
	logic wr;
	logic wr_c0;
	logic wr_c1;
	logic wr_cnt;
	logic wr_per;
	logic wr_irq;
	logic [7:0] wbyte;
	logic [1:0] pre_sel;
	logic [3:0] post_sel;
	logic [2:0] src_sel;
	logic rise_en;
	logic fall_en;
	logic rise_edge;
	logic fall_edge;
	logic src_now;
	logic edge_hit;
	logic level_hit;
	logic ext_clr;
	logic running;
	logic tick;
	logic at_period;
	logic match;
	logic post_ovf;

	// ************************************************************
	// Bus and field decode
	// ************************************************************
	assign src_vec = {gen_output1, gen_output0, gen_fault_pin,
		comparator2_out, comparator1_out, capture_compare_out};
	assign req = avs_read | avs_write;
	// One wait cycle so read data come straight from a flip-flop
	assign avs_waitrequest = req & ~s_r.ack;
	assign avs_readdata = {24'h000000, s_r.rdata};
	assign wr = avs_write & s_r.ack;
	assign wbyte = avs_writedata[7:0];
	assign wr_c0 = wr & (avs_address == OFS_CONTROL0);
	assign wr_c1 = wr & (avs_address == OFS_CONTROL1);
	assign wr_cnt = wr & (avs_address == OFS_COUNT);
	assign wr_per = wr & (avs_address == OFS_PERIOD);
	assign wr_irq = wr & (avs_address == OFS_IRQ);
	assign limit_match = s_r.match;
	assign limit_irq = s_r.irq;

	assign pre_sel = s_r.control0[C0_PRE_LSB +: 2];
	assign post_sel = s_r.control0[C0_POST_LSB +: 4];
	assign src_sel = s_r.control1[C1_SRC_LSB +: 3];
	assign rise_en = s_r.control1[C1_RISE_EN];
	assign fall_en = s_r.control1[C1_FALL_EN];
	assign rise_edge = s_r.control1[C1_RISE_EDGE];
	assign fall_edge = s_r.control1[C1_FALL_EDGE];

	// ************************************************************
	// External reset detection
	// ************************************************************
	assign src_now = src_pick(src_sel, s_r.sync2);
	assign edge_hit = (rise_en & rise_edge & src_now & ~s_r.src_prev)
		| (fall_en & fall_edge & ~src_now & s_r.src_prev);
	assign level_hit = (rise_en & ~rise_edge & src_now)
		| (fall_en & ~fall_edge & ~src_now);
	assign ext_clr = s_r.pend | edge_hit | level_hit;

	// ************************************************************
	// Timebase
	// ************************************************************
	// Ref clock stands for the instruction clock
	assign running = s_r.control0[C0_ON] & ~sleep_mode;
	assign tick = running & ~wr_c0 & ~wr_cnt
		& ((s_r.presc & pre_mask(pre_sel)) == pre_mask(pre_sel));
	assign at_period = s_r.count == s_r.period;
	assign match = tick & ~ext_clr & at_period;
	assign post_ovf = match & (s_r.post == post_sel);

	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = req & ~s_r.ack;
		s_nxt.sync1 = src_vec;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.src_prev = src_now;
		s_nxt.match = match;
		s_nxt.irq = s_r.flag & s_r.irq_en;
		if (avs_read & ~s_r.ack) begin
			if (avs_address == OFS_CONTROL0) begin
				s_nxt.rdata = s_r.control0;
			end else if (avs_address == OFS_CONTROL1) begin
				s_nxt.rdata = s_r.control1;
			end else if (avs_address == OFS_COUNT) begin
				s_nxt.rdata = s_r.count;
			end else if (avs_address == OFS_PERIOD) begin
				s_nxt.rdata = s_r.period;
			end else if (avs_address == OFS_IRQ) begin
				s_nxt.rdata = {6'h00, s_r.irq_en, s_r.flag};
			end else begin
				s_nxt.rdata = 8'h00;
			end
		end
		if (wr_c0) begin
			s_nxt.control0 = wbyte & C0_MASK;
		end
		if (wr_c1) begin
			s_nxt.control1 = wbyte & C1_MASK;
		end
		if (wr_per) begin
			s_nxt.period = wbyte;
		end
		if (wr_irq) begin
			s_nxt.irq_en = wbyte[IRQ_EN];
		end
		// Hardware set wins over a software clear
		s_nxt.flag = post_ovf
			| (wr_irq ? wbyte[IRQ_FLAG] : s_r.flag);
		// Scalers restart on count or control0 writes
		if (wr_c0 | wr_cnt) begin
			s_nxt.presc = PRESC_RST;
			s_nxt.post = POST_RST;
		end else begin
			if (running) begin
				s_nxt.presc = s_r.presc + 6'h01;
			end
			if (match) begin
				s_nxt.post = post_ovf ? POST_RST
					: s_r.post + 4'h1;
			end
		end
		// Count write takes precedence and drops pending resets
		if (wr_cnt) begin
			s_nxt.count = wbyte;
			s_nxt.pend = 1'b0;
		end else if (tick) begin
			s_nxt.pend = 1'b0;
			if (ext_clr | at_period) begin
				s_nxt.count = COUNT_RST;
			end else begin
				s_nxt.count = s_r.count + 8'h01;
			end
		end else begin
			s_nxt.pend = s_r.pend | edge_hit;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
			s_r.control0 <= CONTROL_RST;
			s_r.control1 <= CONTROL_RST;
			s_r.count <= COUNT_RST;
			s_r.period <= PERIOD_RST;
			s_r.presc <= PRESC_RST;
			s_r.post <= POST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	chk_match_wrap: assert property (s_r.match |-> s_r.count == 8'h00
		&& $past(s_r.count) == $past(s_r.period))
		else $error("match without period wrap");
	chk_ctrl0_keep: assert property (wr_c0 |=>
		s_r.count == $past(s_r.count) && s_r.presc == 6'h00)
		else $error("control0 write disturbed count");
	chk_cnt_write: assert property (wr_cnt |=>
		s_r.count == $past(wbyte) && !s_r.pend && s_r.post == 4'h0)
		else $error("count write lost");
	chk_sleep_hold: assert property (sleep_mode && !wr_cnt |=>
		$stable(s_r.count))
		else $error("count moved in sleep");
	chk_off_hold: assert property (!s_r.control0[C0_ON] && !wr_cnt
		|=> $stable(s_r.count))
		else $error("count moved while off");
	chk_irq_gate: assert property (s_r.irq |->
		$past(s_r.flag) && $past(s_r.irq_en))
		else $error("irq without enable");
	chk_flag_set: assert property (post_ovf |=> s_r.flag)
		else $error("postscaler overflow lost");
	chk_ext_clear: assert property (tick && ext_clr && !wr_cnt
		|=> s_r.count == 8'h00 && !s_r.match)
		else $error("external reset missed");
	chk_presc_div: assert property (tick && pre_sel == 2'h2 |->
		s_r.presc[3:0] == 4'hf)
		else $error("prescaler divide wrong");
	chk_bus_answer: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");

	cov_match: cover property (s_r.match);
	cov_ext_reset: cover property (tick && ext_clr && at_period);
	cov_irq: cover property (s_r.irq);
	cov_post_ovf: cover property (post_ovf);
	cov_level_hit: cover property (tick && level_hit);

	// ************************************************************
	// Reset source checks
	// ************************************************************

	// Reserved codes must never leak a live source
	chk_src_reserved: assert property (src_sel[2:1] == 2'b11
		|-> !src_now)
		else $error("reserved source not zero");

	// Edge clears land on the tick itself
	chk_rise_edge: assert property (tick && rise_en && rise_edge
		&& src_now && !s_r.src_prev |=> s_r.count == 8'h00)
		else $error("rising edge clear missed");

	chk_fall_edge: assert property (tick && fall_en && fall_edge
		&& !src_now && s_r.src_prev |=> s_r.count == 8'h00)
		else $error("falling edge clear missed");

	// Level mode keeps the count pinned while present
	chk_rise_level: assert property (tick && rise_en && !rise_edge
		&& src_now |=> s_r.count == 8'h00)
		else $error("rising level clear missed");

	chk_fall_level: assert property (tick && fall_en && !fall_edge
		&& !src_now |=> s_r.count == 8'h00)
		else $error("falling level clear missed");

	// Disabled events must not disturb the count
	chk_no_enable: assert property (!rise_en && !fall_en
		&& !s_r.pend |-> !ext_clr)
		else $error("clear without enable");

	// Edge events between prescaled ticks wait for the next one
	chk_pend_hold: assert property (edge_hit && !tick && !wr_cnt
		|=> s_r.pend)
		else $error("edge event dropped");

	// ************************************************************
	// Timebase and scaler checks
	// ************************************************************

	chk_post_one: assert property (match && post_sel == 4'h0
		|=> s_r.flag)
		else $error("postscale 1:1 missed");

	// Postscaler restarts on control0 writes, so it never overshoots
	chk_post_range: assert property (s_r.post <= post_sel)
		else $error("postscaler past select");

	chk_unused_bits: assert property (!s_r.control0[7]
		&& !s_r.control1[5])
		else $error("unused control bit set");

	chk_count_step: assert property (tick && !ext_clr && !at_period
		|=> s_r.count == $past(s_r.count) + 8'h01)
		else $error("count did not step");

	chk_off_no_tick: assert property (!running |-> !tick)
		else $error("tick while stopped");

	// Output means timeout only, never a cleared period
	chk_match_cause: assert property (s_r.match |->
		$past(tick) && !$past(ext_clr))
		else $error("match despite clear");

	chk_irq_follow: assert property (s_r.flag && s_r.irq_en
		|=> s_r.irq)
		else $error("enabled irq not raised");

	chk_scaler_clear: assert property (wr_cnt |=>
		s_r.presc == 6'h00)
		else $error("prescaler kept on count write");

	chk_period_write: assert property (wr_per |=>
		s_r.period == $past(wbyte))
		else $error("period write lost");

	// ************************************************************
	// Bus checks
	// ************************************************************

	// First cycle of each request always waits
	chk_wait_first: assert property (req && !s_r.ack |-> avs_waitrequest)
		else $error("no wait on first cycle");

	// Upper lanes are unused and must read zero
	chk_read_upper: assert property (avs_readdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");

endmodule
`default_nettype wire

// [hwlt_pkg.sv]
// Constants, register map and state type of the limit timer
package hwlt_pkg;

	// ************************************************************
	// Register byte addresses
	// ************************************************************
	localparam logic [4:0] OFS_CONTROL0 = 5'h00;
	localparam logic [4:0] OFS_CONTROL1 = 5'h04;
	localparam logic [4:0] OFS_COUNT = 5'h08;
	localparam logic [4:0] OFS_PERIOD = 5'h0c;
	localparam logic [4:0] OFS_IRQ = 5'h10;

	// ************************************************************
	// Values after reset
	// ************************************************************
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'hff;
	localparam logic [5:0] PRESC_RST = 6'h00;
	localparam logic [3:0] POST_RST = 4'h0;

	// ************************************************************
	// Field positions and implemented-bit masks
	// ************************************************************
	localparam int C0_PRE_LSB = 0;
	localparam int C0_ON = 2;
	localparam int C0_POST_LSB = 3;
	localparam int C1_RISE_EN = 0;
	localparam int C1_FALL_EN = 1;
	localparam int C1_SRC_LSB = 2;
	localparam int C1_RISE_EDGE = 6;
	localparam int C1_FALL_EDGE = 7;
	localparam logic [7:0] C0_MASK = 8'h7f;
	localparam logic [7:0] C1_MASK = 8'hdf;
	localparam int IRQ_FLAG = 0;
	localparam int IRQ_EN = 1;

	// ************************************************************
	// Prescaler terminal masks and reset sources
	// ************************************************************
	localparam logic [5:0] PRE_MASK1 = 6'h00;
	localparam logic [5:0] PRE_MASK4 = 6'h03;
	localparam logic [5:0] PRE_MASK16 = 6'h0f;
	localparam logic [5:0] PRE_MASK64 = 6'h3f;
	localparam int SRC_CNT = 6;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic [7:0] control0;
		logic [7:0] control1;
		logic [7:0] count;
		logic [7:0] period;
		logic flag;
		logic irq_en;
		logic [5:0] presc;
		logic [3:0] post;
		logic pend;
		logic [SRC_CNT-1:0] sync1;
		logic [SRC_CNT-1:0] sync2;
		logic src_prev;
		logic match;
		logic irq;
	} hwlt_state_type;

endpackage

// [hwlt_periph_model.sv]
// Behavioural model of the peripherals that feed the timer resets
`timescale 1ns/1ps
`default_nettype none
module hwlt_periph_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [2:0] sel,
	input wire logic lvl,
	output logic [5:0] src
);
	// ************************************************************
	// Selected output follows the request, the others idle low
	// ************************************************************
	// Outputs are launched from the clock, like real peripheral logic
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			src <= 6'h00;
		end else begin
			src <= 6'h00;
			if (sel < 3'h6) begin
				src[sel] <= lvl;
			end
		end
	end
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench of the limit timer
`timescale 1ns/1ps
`default_nettype none
module tb;
	import hwlt_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sleep_mode = 1'b0;
	logic [2:0] psel = 3'h0;
	logic plvl = 1'b0;
	logic [5:0] src;
	logic limit_match;
	logic limit_irq;
	int mismatches = 0;
	int checked = 0;
	int nmatch = 0;
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (limit_match === 1'b1) nmatch++;
	end
	hwlt_timer hwlt_timer_i (.ref_clk(ref_clk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sleep_mode(sleep_mode), .capture_compare_out(src[0]),
		.comparator1_out(src[1]), .comparator2_out(src[2]),
		.gen_fault_pin(src[3]), .gen_output0(src[4]),
		.gen_output1(src[5]), .limit_match(limit_match),
		.limit_irq(limit_irq));
	hwlt_periph_model hwlt_periph_model_i (.ref_clk(ref_clk),
		.resetn(resetn), .sel(psel), .lvl(plvl), .src(src));
	// ************************************************************
	// Bus cycles and comparisons
	// ************************************************************
	task automatic finish_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s,
		input logic [7:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Waitrequest is read at the rising edge, before the design updates
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			chk("waitrequest", 8'h01, 8'h00);
			finish_test();
		end
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// Idle edge so the next call never re-drives a strobe
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] q);
		bus(1'b0, a, 8'h00, q);
	endtask
	task automatic rd_chk(input string nm, input logic [4:0] a,
		input logic [7:0] e);
		logic [7:0] q;
		rd(a, q);
		chk(nm, q, e);
	endtask
	// Kind 0 untouched, 1 cleared once, 2 held at zero
	task automatic ext(input logic [7:0] c1, input logic pre, input int k);
		logic [7:0] v;
		logic ok;
		plvl <= pre;
		psel <= c1[4:2];
		wr(OFS_CONTROL1, c1);
		repeat (6) @(posedge ref_clk);
		wr(OFS_COUNT, 8'h80);
		plvl <= ~pre;
		repeat (8) @(posedge ref_clk);
		rd(OFS_COUNT, v);
		ok = k == 0 ? v >= 8'h80 : k == 1 ? v != 0 && v < 8'h0c : v == 0;
		chk("ext reset", 8'(ok), 8'h01);
	endtask
	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		logic [7:0] q;
		int c;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd_chk("control0", OFS_CONTROL0, CONTROL_RST);
		rd_chk("control1", OFS_CONTROL1, CONTROL_RST);
		rd_chk("count", OFS_COUNT, COUNT_RST);
		rd_chk("period", OFS_PERIOD, PERIOD_RST);
		rd_chk("unmapped", 5'h14, 8'h00);
		wr(OFS_CONTROL1, 8'hff);
		rd_chk("control1 bits", OFS_CONTROL1, 8'hdf);
		wr(OFS_CONTROL0, 8'hff);
		rd_chk("control0 bits", OFS_CONTROL0, 8'h7f);
		wr(OFS_CONTROL1, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_CONTROL0, 8'h04 | 8'(k));
			wr(OFS_COUNT, 8'h00);
			repeat (128) @(posedge ref_clk);
			rd(OFS_COUNT, q);
			c = 128 >> (2 * k);
			chk("prescale", 8'(q >= c && q <= c + 3), 8'h01);
		end
		wr(OFS_CONTROL0, 8'h04);
		repeat (40) @(posedge ref_clk);
		wr(OFS_CONTROL0, 8'h00);
		rd(OFS_COUNT, q);
		chk("count kept", 8'(q >= 8'h28), 8'h01);
		repeat (30) @(posedge ref_clk);
		rd_chk("stopped", OFS_COUNT, q);
		wr(OFS_CONTROL0, 8'h04);
		sleep_mode <= 1'b1;
		rd(OFS_COUNT, q);
		repeat (30) @(posedge ref_clk);
		rd_chk("sleep", OFS_COUNT, q);
		sleep_mode <= 1'b0;
		wr(OFS_CONTROL0, 8'h00);
		wr(OFS_PERIOD, 8'h09);
		wr(OFS_IRQ, 8'h02);
		// Period 9, postscale 1:2, interrupt enabled
		wr(OFS_CONTROL0, 8'h0c);
		wr(OFS_COUNT, 8'h00);
		c = nmatch;
		repeat (12) @(posedge ref_clk);
		rd_chk("post first", OFS_IRQ, 8'h02);
		repeat (10) @(posedge ref_clk);
		rd_chk("post second", OFS_IRQ, 8'h03);
		chk("irq out", 8'(limit_irq), 8'h01);
		repeat (60) @(posedge ref_clk);
		c = nmatch - c;
		chk("match pulses", 8'(c >= 7 && c <= 9), 8'h01);
		wr(OFS_CONTROL0, 8'h00);
		wr(OFS_IRQ, 8'h02);
		rd_chk("flag clear", OFS_IRQ, 8'h02);
		chk("irq drop", 8'(limit_irq), 8'h00);
		wr(OFS_IRQ, 8'h00);
		wr(OFS_CONTROL0, 8'h04);
		repeat (30) @(posedge ref_clk);
		chk("irq masked", 8'(limit_irq), 8'h00);
		wr(OFS_CONTROL0, 8'h00);
		rd_chk("flag masked", OFS_IRQ, 8'h01);
		wr(OFS_IRQ, 8'h00);
		wr(OFS_PERIOD, 8'hff);
		wr(OFS_CONTROL0, 8'h04);
		ext(8'h41, 1'b0, 1);
		ext(8'h49, 1'b1, 0);
		ext(8'h86, 1'b1, 1);
		ext(8'h16, 1'b1, 2);
		ext(8'h11, 1'b0, 2);
		// Level still present: count pinned, period never reached
		wr(OFS_PERIOD, 8'h09);
		c = nmatch;
		repeat (30) @(posedge ref_clk);
		chk("no match", 8'(nmatch - c), 8'h00);
		ext(8'h59, 1'b0, 0);
		ext(8'h40, 1'b0, 0);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd_chk("period again", OFS_PERIOD, PERIOD_RST);
		rd_chk("control1 again", OFS_CONTROL1, CONTROL_RST);
		finish_test();
	end
	// Whole run takes about a thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		$display("BAD watchdog expected finish seen timeout");
		finish_test();
	end
endmodule
`default_nettype wire
